/* rtl/flash_erase_pkg.sv */
// constants, opcodes and state codes for the erase and power sequencer
// Overview of operation
// - page clear sets every bit of the addressed 256-byte page to one.
// - erase needs the write unlock latch; unlock command sets it once decoded.
// - page clear is command byte plus three address bytes, any in-page address.
// - the top four of the 24 address bits are ignored.
// - select must rise on the byte boundary after the last address bit.
// - valid erase starts a self-timed cycle with busy flag high throughout.
// - write unlock latch is cleared during every erase cycle.
// - page clear to a hardware-protected page is not executed.
// - block wipe sets every bit of the addressed 64-Kbyte sector to one.
// - block wipe of a sector holding a protected page is not executed.
// - while a cycle runs, erase, sleep and wake commands are rejected.
// - in deep sleep every write, program and erase command is ignored.
// - select high with no cycle pending gives standby; sleep only by command.
// - sleep command is one byte, select rising right after its last bit.
// - after a valid sleep command wait the entry delay, then sleep.
// - wake is rejected if extra clocks follow its command byte.
// - after wake, standby follows the wake delay; host keeps select high.
// - deep sleep never survives power-up; power-up lands in standby.
// - while power-on clear is asserted all logic is held in reset.
// - for the power-up write delay, unlock, program and erase are ignored.
// - power-up leaves standby with unlock latch and busy flag cleared.
// - every serial bit is sampled on the rising serial clock edge.
package flash_erase_pkg;

   localparam int unsigned CLK_FREQ_MHZ           = 125;

   // self-timed delays in their own units
   localparam int unsigned PAGE_CLEAR_TIME_US     = 10000;
   localparam int unsigned BLOCK_WIPE_TIME_US     = 200000;
   localparam int unsigned SLEEP_ENTRY_DELAY_NS   = 3000;
   localparam int unsigned WAKE_DELAY_NS          = 30000;
   localparam int unsigned POWERUP_WRITE_DELAY_US = 1000;

   // the same delays in system clock cycles, least times rounded up
   localparam int unsigned PAGE_CLEAR_CYC   = PAGE_CLEAR_TIME_US * CLK_FREQ_MHZ;
   localparam int unsigned BLOCK_WIPE_CYC   = BLOCK_WIPE_TIME_US * CLK_FREQ_MHZ;
   localparam int unsigned SLEEP_ENTRY_CYC  = (SLEEP_ENTRY_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int unsigned WAKE_CYC         = (WAKE_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int unsigned POWERUP_WRITE_CYC = POWERUP_WRITE_DELAY_US * CLK_FREQ_MHZ;

   // default opcodes
   localparam logic [7:0] WRITE_UNLOCK_OP = 8'h11;
   localparam logic [7:0] PAGE_CLEAR_OP   = 8'h22;
   localparam logic [7:0] BLOCK_WIPE_OP   = 8'h33;
   localparam logic [7:0] DEEP_SLEEP_OP   = 8'h44;
   localparam logic [7:0] WAKE_OP         = 8'h55;

   // frame lengths in serial bits
   localparam logic [5:0] CMD_BITS  = 6'h08;
   localparam logic [5:0] ADDR_BITS = 6'h20;
   localparam logic [5:0] BIT_SAT   = 6'h21;

   // address layout
   localparam int unsigned ADDR_USED_W = 20;
   localparam int unsigned PAGE_LSB    = 8;
   localparam int unsigned SECTOR_LSB  = 16;
   localparam logic [3:0]  PROT_SECTOR = 4'h0;

   // reset values
   localparam logic       SYNC_RST_VAL = 1'b1;
   localparam logic [5:0] BITCNT_RST   = 6'h00;
   localparam logic [31:0] TIMER_RST   = 32'h0000_0000;

   typedef enum logic [4:0] {
      ST_STANDBY     = 5'h01,
      ST_ERASE       = 5'h02,
      ST_SLEEP_ENTRY = 5'h04,
      ST_SLEEP       = 5'h08,
      ST_WAKE        = 5'h10
   } pstate_e;

endpackage

/* rtl/serial_flash_erase_power_ctrl.sv */
// erase, deep sleep and power-up write inhibit sequencer of a serial flash
`timescale 1ns/1ns
module serial_flash_erase_power_ctrl
   import flash_erase_pkg::*;
#(
   parameter int unsigned    PAGE_CLEAR_CYCLES = PAGE_CLEAR_CYC,
   parameter int unsigned    BLOCK_WIPE_CYCLES = BLOCK_WIPE_CYC,
   parameter int unsigned    WAKE_CYCLES       = WAKE_CYC,
   parameter int unsigned    POWERUP_CYCLES    = POWERUP_WRITE_CYC,
   parameter logic [7:0]     OP_WRITE_UNLOCK   = WRITE_UNLOCK_OP,
   parameter logic [7:0]     OP_PAGE_CLEAR     = PAGE_CLEAR_OP,
   parameter logic [7:0]     OP_BLOCK_WIPE     = BLOCK_WIPE_OP,
   parameter logic [7:0]     OP_DEEP_SLEEP     = DEEP_SLEEP_OP,
   parameter logic [7:0]     OP_WAKE           = WAKE_OP
)(
   input  wire logic                   sys_clk_i,
   input  wire logic                   arst_n_i,
   input  wire logic                   link_sck_i,
   input  wire logic                   link_cs_n_i,
   input  wire logic                   link_mosi_i,
   input  wire logic                   write_protect_n_i,
   input  wire logic                   ext_cycle_busy_i,
   output logic                        busy_flag_o,
   output logic                        write_unlock_latch_o,
   output logic                        standby_o,
   output logic                        deep_sleep_o,
   output logic                        powerup_lock_o,
   output logic                        erase_go_o,
   output logic                        erase_block_o,
   output logic [ADDR_USED_W-1:0]      erase_base_o,
   output logic                        erase_done_o
);

   ////////////////////////////////////////////////////////////////////
   // parameter checks

   if (PAGE_CLEAR_CYCLES < 2 || BLOCK_WIPE_CYCLES < 2)
   begin : g_chk_erase
      $error("erase cycle counts must be at least 2");
   end
   if (WAKE_CYCLES < 1 || POWERUP_CYCLES < 1)
   begin : g_chk_delay
      $error("delay counts must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////
   // link clock domain: serial shift-in

   logic        frame_start_q;
   logic [5:0]  bitcnt_q;
   logic [31:0] shift_q;
   logic        frame_tog_q;
   logic        link_first_rst;

   // select high marks the next edge as a frame's first bit
   assign link_first_rst = link_cs_n_i | ~arst_n_i;

   always_ff @(posedge link_sck_i or posedge link_first_rst)
   begin
      if (link_first_rst)
         frame_start_q <= 1'b1;
      else
         frame_start_q <= 1'b0;
   end

   // bit count saturates so overlong frames never look exact
   always_ff @(posedge link_sck_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         bitcnt_q <= BITCNT_RST;
      else if (frame_start_q)
         bitcnt_q <= 6'h01;
      else if (bitcnt_q != BIT_SAT)
         bitcnt_q <= bitcnt_q + 6'h01;
   end

   // msb first, sampled on the rising edge
   always_ff @(posedge link_sck_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         shift_q <= 32'h0000_0000;
      else if (frame_start_q)
         shift_q <= {31'h0000_0000, link_mosi_i};
      else
         shift_q <= {shift_q[30:0], link_mosi_i};
   end

   // flips once per clocked frame, lets the system side skip empty frames
   always_ff @(posedge link_sck_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         frame_tog_q <= 1'b0;
      else if (frame_start_q)
         frame_tog_q <= ~frame_tog_q;
   end

   ////////////////////////////////////////////////////////////////////
   // system domain: pin synchronisers

   logic [1:0] pin_raw;
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic [1:0] pin_s3_q;
   logic [1:0] pin_lvl_q;

   assign pin_raw = {write_protect_n_i, link_cs_n_i};

   for (genvar i = 0; i < 2; i++)
   begin : g_sync
      always_ff @(posedge sys_clk_i or negedge arst_n_i)
      begin
         if (!arst_n_i)
         begin
            pin_s1_q[i]  <= SYNC_RST_VAL;
            pin_s2_q[i]  <= SYNC_RST_VAL;
            pin_s3_q[i]  <= SYNC_RST_VAL;
            pin_lvl_q[i] <= SYNC_RST_VAL;
         end
         else
         begin
            pin_s1_q[i] <= pin_raw[i];
            pin_s2_q[i] <= pin_s1_q[i];
            pin_s3_q[i] <= pin_s2_q[i];
            if (pin_s2_q[i] == pin_s3_q[i])
               pin_lvl_q[i] <= pin_s3_q[i];
         end
      end
   end

   logic cs_rise;
   logic cs_high;
   logic protect_on;

   assign cs_rise    = pin_s2_q[0] & pin_s3_q[0] & ~pin_lvl_q[0];
   assign cs_high    = pin_lvl_q[0];
   assign protect_on = ~pin_lvl_q[1];

   ////////////////////////////////////////////////////////////////////
   // frame capture at select rise
   // link registers are still while select is high, so they are read directly

   logic        seen_tog_q;
   logic        frame_new;
   logic        len_cmd;
   logic        len_addr;
   logic [7:0]  op_byte;

   assign frame_new = cs_rise & (frame_tog_q != seen_tog_q);
   assign len_cmd   = (bitcnt_q == CMD_BITS);
   assign len_addr  = (bitcnt_q == ADDR_BITS);
   assign op_byte   = len_addr ? shift_q[31:24] : shift_q[7:0];

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         seen_tog_q <= 1'b0;
      else if (cs_rise)
         seen_tog_q <= frame_tog_q;
   end

   // exact lengths only: byte boundary after the last bit
   logic is_unlock;
   logic is_page;
   logic is_block;
   logic is_sleep;
   logic is_wake;

   assign is_unlock = frame_new & len_cmd & (op_byte == OP_WRITE_UNLOCK);
   assign is_page   = frame_new & len_addr & (op_byte == OP_PAGE_CLEAR);
   assign is_block  = frame_new & len_addr & (op_byte == OP_BLOCK_WIPE);
   assign is_sleep  = frame_new & len_cmd & (op_byte == OP_DEEP_SLEEP);
   assign is_wake   = frame_new & len_cmd & (op_byte == OP_WAKE);

   // top four address bits dropped
   logic [ADDR_USED_W-1:0] addr_used;
   logic                   target_prot;

   assign addr_used   = shift_q[ADDR_USED_W-1:0];
   // protection covers whole pages of one sector, so both checks coincide
   assign target_prot = protect_on & (addr_used[ADDR_USED_W-1:SECTOR_LSB] == PROT_SECTOR);

   ////////////////////////////////////////////////////////////////////
   // power-up write inhibit

   logic [31:0] puw_cnt_q;
   logic        puw_lock_q;

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         puw_cnt_q  <= TIMER_RST;
         puw_lock_q <= 1'b1;
      end
      else if (puw_lock_q)
      begin
         puw_cnt_q <= puw_cnt_q + 32'h0000_0001;
         if (puw_cnt_q == POWERUP_CYCLES - 1)
            puw_lock_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power and cycle state machine

   pstate_e     state_q;
   logic [31:0] tmr_q;
   logic        cycle_running;
   logic        may_write;
   logic        erase_ok;

   // an outside program or rewrite cycle blocks us like our own
   assign cycle_running = (state_q == ST_ERASE) | ext_cycle_busy_i;
   assign may_write = (state_q == ST_STANDBY) & ~cycle_running & ~puw_lock_q;
   assign erase_ok  = may_write & write_unlock_latch_o & ~target_prot;

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_q <= ST_STANDBY;
         tmr_q   <= TIMER_RST;
      end
      else
      begin
         case (state_q)
            ST_STANDBY:
            begin
               if (erase_ok & is_page)
               begin
                  state_q <= ST_ERASE;
                  tmr_q   <= PAGE_CLEAR_CYCLES - 1;
               end
               else if (erase_ok & is_block)
               begin
                  state_q <= ST_ERASE;
                  tmr_q   <= BLOCK_WIPE_CYCLES - 1;
               end
               else if (is_sleep & ~ext_cycle_busy_i)
               begin
                  state_q <= ST_SLEEP_ENTRY;
                  tmr_q   <= SLEEP_ENTRY_CYC - 1;
               end
            end
            ST_ERASE:
            begin
               // commands arriving now fall through untouched
               if (tmr_q == TIMER_RST)
                  state_q <= ST_STANDBY;
               else
                  tmr_q <= tmr_q - 32'h0000_0001;
            end
            ST_SLEEP_ENTRY:
            begin
               if (tmr_q == TIMER_RST)
                  state_q <= ST_SLEEP;
               else
                  tmr_q <= tmr_q - 32'h0000_0001;
            end
            ST_SLEEP:
            begin
               // only an exact wake frame leaves sleep
               if (is_wake)
               begin
                  state_q <= ST_WAKE;
                  tmr_q   <= WAKE_CYCLES - 1;
               end
            end
            ST_WAKE:
            begin
               if (tmr_q == TIMER_RST)
                  state_q <= ST_STANDBY;
               else
                  tmr_q <= tmr_q - 32'h0000_0001;
            end
            default:
            begin
               state_q <= ST_STANDBY;
               tmr_q   <= TIMER_RST;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // write unlock latch

   logic erase_start;

   assign erase_start = erase_ok & (is_page | is_block);

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         write_unlock_latch_o <= 1'b0;
      else if (erase_start)
         write_unlock_latch_o <= 1'b0;
      else if (is_unlock & may_write)
         write_unlock_latch_o <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // status and erase command outputs

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         busy_flag_o <= 1'b0;
      else if (erase_start)
         busy_flag_o <= 1'b1;
      else if (state_q == ST_ERASE && tmr_q == TIMER_RST)
         busy_flag_o <= 1'b0;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         erase_go_o    <= 1'b0;
         erase_block_o <= 1'b0;
         erase_base_o  <= '0;
      end
      else
      begin
         erase_go_o <= erase_start;
         if (erase_start)
         begin
            erase_block_o <= is_block;
            // base of page or sector; the array fills it with ones
            if (is_block)
               erase_base_o <= {addr_used[ADDR_USED_W-1:SECTOR_LSB],
                                16'h0000};
            else
               erase_base_o <= {addr_used[ADDR_USED_W-1:PAGE_LSB],
                                8'h00};
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         erase_done_o <= 1'b0;
      else
         erase_done_o <= (state_q == ST_ERASE) && (tmr_q == TIMER_RST);
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         standby_o      <= 1'b0;
         deep_sleep_o   <= 1'b0;
         powerup_lock_o <= 1'b1;
      end
      else
      begin
         standby_o      <= (state_q == ST_STANDBY) & cs_high & ~ext_cycle_busy_i;
         deep_sleep_o   <= (state_q == ST_SLEEP);
         powerup_lock_o <= puw_lock_q;
      end
   end

endmodule // serial_flash_erase_power_ctrl

/* tb/flash_ctrl_monitor.sv */
// concurrent checks of the erase and power sequencer ports
`timescale 1ns/1ns
module flash_ctrl_monitor
   import flash_erase_pkg::*;
#(
   parameter int unsigned PAGE_CLEAR_CYCLES = 20,
   parameter int unsigned BLOCK_WIPE_CYCLES = 40
)(
   input wire logic                   sys_clk_i,
   input wire logic                   arst_n_i,
   input wire logic                   link_sck_i,
   input wire logic                   link_cs_n_i,
   input wire logic                   link_mosi_i,
   input wire logic                   write_protect_n_i,
   input wire logic                   ext_cycle_busy_i,
   input wire logic                   busy_flag_o,
   input wire logic                   write_unlock_latch_o,
   input wire logic                   standby_o,
   input wire logic                   deep_sleep_o,
   input wire logic                   powerup_lock_o,
   input wire logic                   erase_go_o,
   input wire logic                   erase_block_o,
   input wire logic [ADDR_USED_W-1:0] erase_base_o,
   input wire logic                   erase_done_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   ////////////////////////////////////////////////////////////////////
   // length of the current busy run
   logic [31:0] busy_cnt_q;

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         busy_cnt_q <= 32'h0000_0000;
      else if (busy_flag_o)
         busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
      else
         busy_cnt_q <= 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////
   a_go_busy_pulse: assert property (erase_go_o |-> busy_flag_o ##1 !erase_go_o)
      else $error("start without busy or long start pulse");
   a_busy_length: assert property (erase_done_o |-> !busy_flag_o &&
      busy_cnt_q == (erase_block_o ? BLOCK_WIPE_CYCLES : PAGE_CLEAR_CYCLES))
      else $error("busy run of wrong length");
   a_busy_end_done: assert property ($fell(busy_flag_o) |-> erase_done_o)
      else $error("busy fell without done");
   a_latch_cleared: assert property (erase_go_o |-> !write_unlock_latch_o)
      else $error("latch kept through erase");
   a_latch_needed: assert property (erase_go_o |-> $past(write_unlock_latch_o))
      else $error("erase without unlock latch");
   a_protect_kept: assert property (erase_go_o && !write_protect_n_i |->
      erase_base_o[19:16] != PROT_SECTOR)
      else $error("erase of protected sector");
   a_base_aligned: assert property (erase_go_o |-> erase_base_o[7:0] == 8'h00 &&
      (!erase_block_o || erase_base_o[15:8] == 8'h00))
      else $error("erase base not aligned");
   a_lock_blocks: assert property (powerup_lock_o |->
      !erase_go_o && !$rose(write_unlock_latch_o))
      else $error("write accepted during power-up lock");
   a_sleep_quiet: assert property (deep_sleep_o |-> !erase_go_o && !busy_flag_o)
      else $error("erase activity in deep sleep");
   a_standby_idle: assert property (standby_o |-> !busy_flag_o && !deep_sleep_o)
      else $error("standby while busy or asleep");
endmodule // flash_ctrl_monitor

bind serial_flash_erase_power_ctrl flash_ctrl_monitor #(
   .PAGE_CLEAR_CYCLES(PAGE_CLEAR_CYCLES),
   .BLOCK_WIPE_CYCLES(BLOCK_WIPE_CYCLES)
) u_mon (.sys_clk_i, .arst_n_i, .link_sck_i, .link_cs_n_i, .link_mosi_i,
   .write_protect_n_i, .ext_cycle_busy_i, .busy_flag_o, .write_unlock_latch_o,
   .standby_o, .deep_sleep_o, .powerup_lock_o, .erase_go_o, .erase_block_o,
   .erase_base_o, .erase_done_o);

/* tb/spi_host_model.sv */
// serial host model driving select, clock and data of the link
`timescale 1ns/1ns
module spi_host_model
(
   input  wire logic sys_clk_i,
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      mosi_o
);
   initial
   begin
      sck_o  = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // n bits of v msb first, clock only inside the frame
   task automatic xfer(input logic [31:0] v, input int n);
      @(posedge sys_clk_i);
      #1 cs_n_o = 1'b0;
      #2;
      for (int i = n - 1; i >= 0; i--)
      begin
         mosi_o = v[i];
         #3 sck_o = 1'b1;
         #3 sck_o = 1'b0;
      end
      #3 cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      repeat (10) @(posedge sys_clk_i);
      #2;
   endtask
endmodule // spi_host_model

/* tb/serial_flash_erase_power_ctrl_bench.sv */
// self-checking bench of the erase and power sequencer
`timescale 1ns/1ns
module serial_flash_erase_power_ctrl_bench;
   import flash_erase_pkg::*;
   localparam int unsigned PC = 20;
   localparam int unsigned BW = 40;
   localparam int unsigned PU = 50;

   logic        clk, rst_n, sck, cs_n, mosi, wp_n, ext;
   logic        busy, latch, stby, sleep, lock, go, blk, done;
   logic [19:0] base;
   logic [19:0] go_base;
   logic        go_blk;
   int          n_fail, checks_done, n_go;

   serial_flash_erase_power_ctrl #(.PAGE_CLEAR_CYCLES(PC), .BLOCK_WIPE_CYCLES(BW),
      .WAKE_CYCLES(10), .POWERUP_CYCLES(PU)) uut (
      .sys_clk_i(clk), .arst_n_i(rst_n), .link_sck_i(sck), .link_cs_n_i(cs_n),
      .link_mosi_i(mosi), .write_protect_n_i(wp_n), .ext_cycle_busy_i(ext),
      .busy_flag_o(busy), .write_unlock_latch_o(latch), .standby_o(stby),
      .deep_sleep_o(sleep), .powerup_lock_o(lock), .erase_go_o(go),
      .erase_block_o(blk), .erase_base_o(base), .erase_done_o(done));

   spi_host_model host (.sys_clk_i(clk), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

   always #4 clk = ~clk;

   // catch each one-cycle start pulse
   always @(posedge clk)
   begin
      if (go === 1'b1)
      begin
         n_go++;
         go_base = base;
         go_blk  = blk;
      end
   end

   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic wait_idle();
      int i;
      i = 0;
      while (busy !== 1'b0)
      begin
         tick(1);
         i++;
         if (i > 100)
         begin
            n_fail++;
            summarize();
         end
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      host.xfer({24'h000000, op}, 8);
   endtask

   task automatic erase(input logic [7:0] op, input logic [23:0] a);
      host.xfer({op, a}, 32);
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      repeat (8) @(posedge clk);
      check({busy, latch, sleep, lock}, 32'h1);
      #1 rst_n = 1'b1;
      tick(1);
      check(stby, 1'b1);
   endtask

   task automatic t_powerup();
      cmd(WRITE_UNLOCK_OP);
      check(latch, 1'b0);
      tick(PU);
      check(lock, 1'b0);
   endtask

   task automatic t_page();
      int g;
      g = n_go;
      cmd(WRITE_UNLOCK_OP);
      check(latch, 1'b1);
      erase(PAGE_CLEAR_OP, 24'hF12345);
      check({busy, latch}, 32'h2);
      check(n_go, g + 1);
      check({go_blk, go_base}, 32'h12300);
      wait_idle();
      tick(1);
      check(stby, 1'b1);
   endtask

   task automatic t_refuse();
      int g;
      g = n_go;
      erase(PAGE_CLEAR_OP, 24'h012345);
      check(busy, 1'b0);
      cmd(WRITE_UNLOCK_OP);
      host.xfer({PAGE_CLEAR_OP, 24'h012345} >> 1, 31);
      check({busy, latch}, 32'h1);
      @(posedge clk);
      #1 ext = 1'b1;
      erase(PAGE_CLEAR_OP, 24'h012345);
      check({busy, stby, n_go == g}, 32'h1);
      @(posedge clk);
      #1 ext = 1'b0;
   endtask

   task automatic t_block();
      erase(BLOCK_WIPE_OP, 24'h0ABCDE);
      check({go_blk, go_base}, 32'h1A0000);
      cmd(DEEP_SLEEP_OP);
      check(busy, 1'b1);
      wait_idle();
      tick(400);
      check(sleep, 1'b0);
   endtask

   task automatic t_protect();
      int g;
      g = n_go;
      @(posedge clk);
      #1 wp_n = 1'b0;
      cmd(WRITE_UNLOCK_OP);
      erase(PAGE_CLEAR_OP, 24'h00FF00);
      check(busy, 1'b0);
      erase(BLOCK_WIPE_OP, 24'hF0ABCD);
      check({busy, n_go == g}, 32'h1);
      erase(PAGE_CLEAR_OP, 24'h010100);
      check({busy, n_go == g + 1}, 32'h3);
      wait_idle();
      @(posedge clk);
      #1 wp_n = 1'b1;
   endtask

   task automatic t_sleep();
      int g;
      host.xfer({23'h000000, DEEP_SLEEP_OP, 1'b0}, 9);
      tick(400);
      check(sleep, 1'b0);
      cmd(WRITE_UNLOCK_OP);
      cmd(DEEP_SLEEP_OP);
      tick(360);
      check(sleep, 1'b0);
      tick(20);
      check({sleep, stby}, 32'h2);
      g = n_go;
      erase(PAGE_CLEAR_OP, 24'h054321);
      check({busy, latch, n_go == g}, 32'h3);
      host.xfer({23'h000000, WAKE_OP, 1'b0}, 9);
      tick(20);
      check(sleep, 1'b1);
      cmd(WAKE_OP);
      check({sleep, stby}, 32'h0);
      tick(10);
      check(stby, 1'b1);
   endtask

   // reset in deep sleep must come back in standby
   task automatic t_resleep();
      cmd(DEEP_SLEEP_OP);
      tick(400);
      check(sleep, 1'b1);
      @(posedge clk);
      #1 rst_n = 1'b0;
      tick(2);
      check({sleep, stby, latch, lock}, 32'h1);
      @(posedge clk);
      #1 rst_n = 1'b1;
      tick(1);
      check({sleep, stby}, 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      clk         = 1'b0;
      rst_n       = 1'b0;
      wp_n        = 1'b1;
      ext         = 1'b0;
      go_base     = 20'h00000;
      go_blk      = 1'b0;
      n_fail      = 0;
      checks_done = 0;
      n_go        = 0;
      t_reset();
      t_powerup();
      t_page();
      t_refuse();
      t_block();
      t_protect();
      t_sleep();
      t_resleep();
      summarize();
   end
endmodule // serial_flash_erase_power_ctrl_bench
